// >>> logic/can_filter_pkg.sv
// constants, field layout and carrier types of the can filter/abort block
package can_filter_pkg;
  localparam logic [5:0] OFS_CTRL0    = 6'h00;
  localparam logic [5:0] OFS_CTRL1    = 6'h01;
  localparam logic [5:0] OFS_TIMING0  = 6'h02;
  localparam logic [5:0] OFS_TIMING1  = 6'h03;
  localparam logic [5:0] OFS_RXFLAG   = 6'h04;
  localparam logic [5:0] OFS_RXIEN    = 6'h05;
  localparam logic [5:0] OFS_TXFLAG   = 6'h06;
  localparam logic [5:0] OFS_TXCTRL   = 6'h07;
  localparam logic [5:0] OFS_ACCCTRL  = 6'h08;
  localparam logic [5:0] OFS_RXERR    = 6'h09;
  localparam logic [5:0] OFS_TXERR    = 6'h0a;
  localparam logic [5:0] OFS_PRIO0    = 6'h0c;
  localparam logic [5:0] OFS_CODE0    = 6'h10;
  localparam logic [5:0] OFS_MASK0    = 6'h14;
  localparam logic [5:0] OFS_RXID0    = 6'h18;
  // rx flag register bit positions, then the control 0 lock/sleep-ack bits and the abort field position
  localparam int BIT_WAKE   = 7;
  localparam int BIT_RXWARN = 6;
  localparam int BIT_TXWARN = 5;
  localparam int BIT_RXPASS = 4;
  localparam int BIT_TXPASS = 3;
  localparam int BIT_BUSOFF = 2;
  localparam int BIT_OVR    = 1;
  localparam int BIT_RXFULL = 0;
  localparam int BIT_LOCK   = 0;
  localparam int BIT_SLPACK = 1;
  localparam int ACK_POS    = 4;
  localparam logic [7:0] RST_CTRL0 = 8'h01;
  localparam logic [2:0] RST_TXE   = 3'h7;
  localparam logic [8:0] WARN_LIMIT    = 9'h060;
  localparam logic [8:0] PASSIVE_LIMIT = 9'h07f;
  localparam logic [8:0] BUSOFF_LIMIT  = 9'h0ff;
  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_DUAL   = 2'h1;
  localparam logic [1:0] MODE_QUAD   = 2'h2;
  localparam logic [1:0] MODE_CLOSED = 2'h3;
  typedef struct packed {
    logic [28:0] id;
    logic        ide;
    logic        rtr;
    logic        srr;
  } rx_frame_s;
  typedef struct packed {
    logic [7:0] data;
    logic [5:0] addr;
    logic       wr;
    logic       rd;
  } reg_req_s;
endpackage

// >>> logic/can_filter_abort_irq.sv
// transmit scheduling/abort, acceptance filter and flag logic of a can node
//
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/1ps
module can_filter_abort_irq #(
  parameter int NBUF         = 3,
  parameter bit STUFF_DEFECT = 1'b1
) (
  input  wire logic                        CLOCK,
  input  wire logic                        RST_N,
  input  wire can_filter_pkg::reg_req_s    REG_REQ,
  output logic [7:0]                       REG_RDATA,
  input  wire logic                        ARB_START,
  input  wire logic                        TX_DONE,
  input  wire logic                        TX_FAIL,
  output logic                             TX_ACTIVE,
  output logic [1:0]                       TX_BUFFER,
  input  wire logic                        RX_FRAME_OK,
  input  wire can_filter_pkg::rx_frame_s   RX_FRAME,
  input  wire logic                        RX_LATE_STUFF,
  input  wire logic [7:0]                  RX_ERR_COUNT,
  input  wire logic [8:0]                  TX_ERR_COUNT,
  input  wire logic                        SLEEP_ACK,
  input  wire logic                        BUS_ACTIVITY,
  output logic                             IRQ_WAKEUP,
  output logic                             IRQ_ERROR,
  output logic                             IRQ_RX,
  output logic                             IRQ_TX
);
  logic [7:0] module_control_0;
  logic [7:0] module_control_1;
  logic [7:0] bus_timing_0;
  logic [7:0] bus_timing_1;
  logic [7:0] rx_flag_reg;
  logic [7:0] rx_irq_en;
  logic [NBUF-1:0] tx_buffer_empty_flag;
  logic [NBUF-1:0] abort_acknowledge;
  logic [NBUF-1:0] abort_request;
  logic [NBUF-1:0] tx_empty_irq_enable;
  logic [1:0] filter_mode;
  logic [1:0] filter_hit_index;
  logic [7:0] local_priority_field [NBUF];
  logic [7:0] acceptance_code_regs [4];
  logic [7:0] acceptance_mask_regs [4];
  logic [31:0] cpu_rx_buffer;
  logic [31:0] shadow_rx_buffer;
  logic [1:0] shadow_hit;
  logic shadow_full;
  logic soft_reset_lock;
  logic wr;
  logic [5:0] wa;
  logic [7:0] wd;
  logic [NBUF-1:0] release_buf;

  assign wr = REG_REQ.wr;
  assign wa = REG_REQ.addr;
  assign wd = REG_REQ.data;
  assign soft_reset_lock = module_control_0[can_filter_pkg::BIT_LOCK];

  function automatic logic byte_hit(input logic [7:0] code,
                                    input logic [7:0] mask,
                                    input logic [7:0] val);
    byte_hit = &(mask | ~(code ^ val));
  endfunction

  // configuration writes; lock guards everything but the lock itself, the priorities, rx enables, tx control and the rx/tx flag writes
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      module_control_0 <= can_filter_pkg::RST_CTRL0;
      module_control_1 <= 8'h00;
      bus_timing_0     <= 8'h00;
      bus_timing_1     <= 8'h00;
      filter_mode      <= can_filter_pkg::MODE_SINGLE;
    end
    else if (wr)
    begin
      if (wa == can_filter_pkg::OFS_CTRL0)
        module_control_0 <= {7'h00, wd[can_filter_pkg::BIT_LOCK]};
      if (soft_reset_lock)
      begin
        if (wa == can_filter_pkg::OFS_CTRL1)
          module_control_1 <= wd;
        if (wa == can_filter_pkg::OFS_TIMING0)
          bus_timing_0 <= wd;
        if (wa == can_filter_pkg::OFS_TIMING1)
          bus_timing_1 <= wd;
        if (wa == can_filter_pkg::OFS_ACCCTRL)
          filter_mode <= wd[5:4];
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_filt
      always_ff @(posedge CLOCK or negedge RST_N)
      begin
        if (!RST_N)
        begin
          acceptance_code_regs[g] <= 8'h00;
          acceptance_mask_regs[g] <= 8'h00;
        end
        else if (wr && soft_reset_lock)
        begin
          if (wa == can_filter_pkg::OFS_CODE0 + 6'(g))
            acceptance_code_regs[g] <= wd;
          if (wa == can_filter_pkg::OFS_MASK0 + 6'(g))
            acceptance_mask_regs[g] <= wd;
        end
      end
    end
    for (g = 0; g < NBUF; g++)
    begin : g_local_priority_field
      always_ff @(posedge CLOCK or negedge RST_N)
      begin
        if (!RST_N)
          local_priority_field[g] <= 8'h00;
        else if (wr && wa == can_filter_pkg::OFS_PRIO0 + 6'(g))
          local_priority_field[g] <= wd;
      end
    end
  endgenerate

  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rx_irq_en           <= 8'h00;
      abort_request       <= '0;
      tx_empty_irq_enable <= '0;
    end
    else
    begin
      if (wr && wa == can_filter_pkg::OFS_RXIEN)
        rx_irq_en <= wd;
      if (wr && wa == can_filter_pkg::OFS_TXCTRL)
      begin
        abort_request       <= wd[can_filter_pkg::ACK_POS +: NBUF];
        tx_empty_irq_enable <= wd[NBUF-1:0];
      end
      else
        abort_request <= abort_request & ~release_buf;
    end
  end

  // transmit scheduling
  logic [NBUF-1:0] aborted;
  logic [NBUF-1:0] pending;
  logic [1:0] next_pick;
  logic next_any;

  assign pending = ~tx_buffer_empty_flag;

  always_comb
  begin
    next_pick = 2'h0;
    next_any  = 1'b0;
    for (int i = 0; i < NBUF; i++)
      if (pending[i] && !(abort_request[i]) && (!next_any ||
          local_priority_field[i] < local_priority_field[next_pick]))
      begin
        next_pick = 2'(i);
        next_any  = 1'b1;
      end
  end

  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      TX_ACTIVE <= 1'b0;
      TX_BUFFER <= 2'h0;
    end
    else if (soft_reset_lock)
      TX_ACTIVE <= 1'b0;  // soft reset stops at once, even mid-frame
    else if (ARB_START && !TX_ACTIVE)
    begin
      TX_ACTIVE <= next_any;
      TX_BUFFER <= next_pick;
    end
    else if (TX_DONE || TX_FAIL)
      TX_ACTIVE <= 1'b0;
  end

  always_comb
  begin
    aborted     = '0;
    release_buf = '0;
    for (int i = 0; i < NBUF; i++)
    begin
      aborted[i] = pending[i] && abort_request[i] && !SLEEP_ACK &&
                   !(TX_ACTIVE && TX_BUFFER == 2'(i));
      release_buf[i] = aborted[i] ||
                       (TX_ACTIVE && TX_DONE && TX_BUFFER == 2'(i));
    end
  end

  // writing one to an empty flag schedules that buffer
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      tx_buffer_empty_flag <= can_filter_pkg::RST_TXE;
      abort_acknowledge    <= '0;
    end
    else
    begin
      for (int i = 0; i < NBUF; i++)
      begin
        if (release_buf[i])
        begin
          tx_buffer_empty_flag[i] <= 1'b1;
          abort_acknowledge[i]    <= aborted[i];
        end
        else if (wr && wa == can_filter_pkg::OFS_TXFLAG && wd[i])
        begin
          tx_buffer_empty_flag[i] <= 1'b0;
          abort_acknowledge[i]    <= 1'b0;
        end
      end
    end
  end

  // acceptance filter
  logic [7:0] idr [4];
  logic [7:0] idr1_cmp;
  logic [7:0] std_pad;
  logic [3:0] hits;
  logic accept;
  logic [1:0] hit_idx;

  always_comb
  begin
    if (RX_FRAME.ide)
    begin
      idr[0] = RX_FRAME.id[28:21];
      idr[1] = {RX_FRAME.id[20:18], RX_FRAME.srr, 1'b1,
                RX_FRAME.id[17:15]};
      idr[2] = RX_FRAME.id[14:7];
      idr[3] = {RX_FRAME.id[6:0], RX_FRAME.rtr};
      std_pad = 8'h00;
    end
    else
    begin
      idr[0] = RX_FRAME.id[10:3];
      idr[1] = {RX_FRAME.id[2:0], RX_FRAME.rtr, 1'b0, 3'h0};
      idr[2] = 8'h00;
      idr[3] = 8'h00;
      std_pad = 8'h07;  // bits past ide are not part of a short id
    end
    idr1_cmp = idr[1];
    if (STUFF_DEFECT && RX_FRAME.ide && RX_LATE_STUFF &&
        filter_mode != can_filter_pkg::MODE_QUAD)
      idr1_cmp = {idr[0][0], idr[1][7:1]};
  end

  always_comb
  begin
    hits = 4'h0;
    case (filter_mode)
      can_filter_pkg::MODE_SINGLE:
        hits[0] = byte_hit(acceptance_code_regs[0],
                           acceptance_mask_regs[0], idr[0]) &&
                  byte_hit(acceptance_code_regs[1],
                           acceptance_mask_regs[1] | std_pad, idr1_cmp) &&
                  (!RX_FRAME.ide ||
                   (byte_hit(acceptance_code_regs[2],
                             acceptance_mask_regs[2], idr[2]) &&
                    byte_hit(acceptance_code_regs[3],
                             acceptance_mask_regs[3], idr[3])));
      can_filter_pkg::MODE_DUAL:
        for (int f = 0; f < 2; f++)
          hits[f] = byte_hit(acceptance_code_regs[2*f],
                             acceptance_mask_regs[2*f], idr[0]) &&
                    byte_hit(acceptance_code_regs[2*f+1],
                             acceptance_mask_regs[2*f+1] | std_pad,
                             idr1_cmp);
      can_filter_pkg::MODE_QUAD:
        for (int f = 0; f < 4; f++)
          hits[f] = byte_hit(acceptance_code_regs[f],
                             acceptance_mask_regs[f], idr[0]);
      default:
        hits = 4'h0;
    endcase
    accept  = |hits;
    hit_idx = hits[0] ? 2'h0 : hits[1] ? 2'h1 :
              hits[2] ? 2'h2 : 2'h3;
  end

  // two stage receive store, flags in rx_flag_reg
  logic rx_take;
  logic copy_bg;
  logic [7:0] cond;
  logic [7:0] cond_d;
  logic [7:0] set_f;
  logic [7:0] clr_f;

  assign rx_take = RX_FRAME_OK && accept && !soft_reset_lock;
  // copy is held off in sleep so the cpu buffer stays put
  assign copy_bg = shadow_full && !rx_flag_reg[0] && !SLEEP_ACK;

  always_comb
  begin
    cond = 8'h00;
    cond[can_filter_pkg::BIT_RXWARN] =
      {1'b0, RX_ERR_COUNT} >= can_filter_pkg::WARN_LIMIT;
    cond[can_filter_pkg::BIT_TXWARN] =
      TX_ERR_COUNT >= can_filter_pkg::WARN_LIMIT;
    cond[can_filter_pkg::BIT_RXPASS] =
      {1'b0, RX_ERR_COUNT} > can_filter_pkg::PASSIVE_LIMIT;
    cond[can_filter_pkg::BIT_TXPASS] =
      TX_ERR_COUNT > can_filter_pkg::PASSIVE_LIMIT;
    cond[can_filter_pkg::BIT_BUSOFF] =
      TX_ERR_COUNT > can_filter_pkg::BUSOFF_LIMIT;
    set_f = cond & ~cond_d;
    set_f[can_filter_pkg::BIT_WAKE] = BUS_ACTIVITY && SLEEP_ACK &&
      rx_irq_en[can_filter_pkg::BIT_WAKE];
    set_f[can_filter_pkg::BIT_OVR] =
      rx_take && rx_flag_reg[0] && shadow_full;
    set_f[can_filter_pkg::BIT_RXFULL] =
      (rx_take && !rx_flag_reg[0]) || copy_bg;
    clr_f = (wr && wa == can_filter_pkg::OFS_RXFLAG) ? wd : 8'h00;
    clr_f = clr_f & ~cond;
  end

  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rx_flag_reg <= 8'h00;
      cond_d      <= 8'h00;
    end
    else
    begin
      cond_d      <= cond;
      rx_flag_reg <= (rx_flag_reg & ~clr_f) | set_f;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      cpu_rx_buffer    <= 32'h0000_0000;
      shadow_rx_buffer <= 32'h0000_0000;
      shadow_full      <= 1'b0;
      shadow_hit       <= 2'h0;
      filter_hit_index <= 2'h0;
    end
    else
    begin
      if (rx_take && !rx_flag_reg[0])
      begin
        cpu_rx_buffer    <= {idr[0], idr[1], idr[2], idr[3]};
        filter_hit_index <= hit_idx;
      end
      else if (copy_bg)
      begin
        cpu_rx_buffer    <= shadow_rx_buffer;
        filter_hit_index <= shadow_hit;
      end
      if (rx_take && rx_flag_reg[0] && !shadow_full)
      begin
        shadow_rx_buffer <= {idr[0], idr[1], idr[2], idr[3]};
        shadow_hit       <= hit_idx;
        shadow_full      <= 1'b1;
      end
      else if (copy_bg)
        shadow_full <= 1'b0;
    end
  end

  // interrupt lines; the processor's global mask sits outside
  assign IRQ_WAKEUP = rx_flag_reg[can_filter_pkg::BIT_WAKE];
  assign IRQ_ERROR  = |(rx_flag_reg[6:1] & rx_irq_en[6:1]);
  assign IRQ_RX     = rx_flag_reg[0] & rx_irq_en[0];
  assign IRQ_TX     = |(tx_buffer_empty_flag & tx_empty_irq_enable);

  // read port; counters only readable
  logic [7:0] next_rdata;

  always_comb
  begin
    next_rdata = 8'h00;
    case (REG_REQ.addr)
      can_filter_pkg::OFS_CTRL0:
        next_rdata = {6'h00, SLEEP_ACK, soft_reset_lock};
      can_filter_pkg::OFS_CTRL1:   next_rdata = module_control_1;
      can_filter_pkg::OFS_TIMING0: next_rdata = bus_timing_0;
      can_filter_pkg::OFS_TIMING1: next_rdata = bus_timing_1;
      can_filter_pkg::OFS_RXFLAG:  next_rdata = rx_flag_reg;
      can_filter_pkg::OFS_RXIEN:   next_rdata = rx_irq_en;
      can_filter_pkg::OFS_TXFLAG:
        next_rdata = {1'b0, abort_acknowledge, 1'b0, tx_buffer_empty_flag};
      can_filter_pkg::OFS_TXCTRL:
        next_rdata = {1'b0, abort_request, 1'b0, tx_empty_irq_enable};
      can_filter_pkg::OFS_ACCCTRL:
        next_rdata = {2'h0, filter_mode, 2'h0, filter_hit_index};
      can_filter_pkg::OFS_RXERR:   next_rdata = RX_ERR_COUNT;
      can_filter_pkg::OFS_TXERR:   next_rdata = TX_ERR_COUNT[7:0];
      default:
      begin
        for (int i = 0; i < 4; i++)
        begin
          if (REG_REQ.addr == can_filter_pkg::OFS_CODE0 + 6'(i))
            next_rdata = acceptance_code_regs[i];
          if (REG_REQ.addr == can_filter_pkg::OFS_MASK0 + 6'(i))
            next_rdata = acceptance_mask_regs[i];
          if (REG_REQ.addr == can_filter_pkg::OFS_RXID0 + 6'(i))
            next_rdata = cpu_rx_buffer[31-8*i -: 8];
        end
        for (int i = 0; i < NBUF; i++)
          if (REG_REQ.addr == can_filter_pkg::OFS_PRIO0 + 6'(i))
            next_rdata = local_priority_field[i];
      end
    endcase
  end

  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
      REG_RDATA <= 8'h00;
    else
      REG_RDATA <= REG_REQ.rd ? next_rdata : 8'h00;
  end
endmodule

// >>> test/can_filter_abort_irq_chk.sv
// port-level assertions for the can filter/abort block
`timescale 1ns/1ps
module can_filter_abort_irq_chk (
  input wire logic                     CLOCK,
  input wire logic                     RST_N,
  input wire can_filter_pkg::reg_req_s REG_REQ,
  input wire logic                     ARB_START,
  input wire logic                     TX_DONE,
  input wire logic                     TX_FAIL,
  input wire logic                     TX_ACTIVE,
  input wire logic [1:0]               TX_BUFFER,
  input wire logic                     RX_FRAME_OK,
  input wire logic [7:0]               RX_ERR_COUNT,
  input wire logic [8:0]               TX_ERR_COUNT,
  input wire logic                     SLEEP_ACK,
  input wire logic                     BUS_ACTIVITY,
  input wire logic                     IRQ_WAKEUP,
  input wire logic                     IRQ_ERROR,
  input wire logic                     IRQ_RX,
  input wire logic                     IRQ_TX
);
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RST_N);
  a_select_on_arb: assert property (
    $rose(TX_ACTIVE) |-> $past(ARB_START))
    else $error("tx active rose without arbitration start");
  a_end_clears_active: assert property (
    (TX_DONE || TX_FAIL) && TX_ACTIVE |=> !TX_ACTIVE)
    else $error("tx active held after done or fail");
  a_active_buffer_held: assert property (
    TX_ACTIVE && $past(TX_ACTIVE) |-> $stable(TX_BUFFER))
    else $error("buffer changed under transmission");
  a_tx_irq_kept: assert property (
    $fell(IRQ_TX) |-> $past(REG_REQ.wr))
    else $error("tx interrupt dropped without a write");
  a_rx_irq_cause: assert property (
    $rose(IRQ_RX) |-> $past(RX_FRAME_OK || REG_REQ.wr || SLEEP_ACK)
      || $past(REG_REQ.wr || SLEEP_ACK, 2))
    else $error("rx interrupt rose without a frame");
  a_rx_irq_held: assert property (
    $fell(IRQ_RX) |-> $past(REG_REQ.wr))
    else $error("rx interrupt dropped without a write");
  a_err_irq_held: assert property (
    $fell(IRQ_ERROR) |-> $past(REG_REQ.wr))
    else $error("error interrupt dropped without a write");
  a_err_irq_cause: assert property (
    $rose(IRQ_ERROR) |-> $past(RX_FRAME_OK || REG_REQ.wr
      || RX_ERR_COUNT >= 8'h60 || TX_ERR_COUNT >= 9'h060))
    else $error("error interrupt rose without a cause");
  a_wake_needs_sleep: assert property (
    $rose(IRQ_WAKEUP) |-> $past(SLEEP_ACK && BUS_ACTIVITY || REG_REQ.wr))
    else $error("wakeup interrupt outside sleep");
  c_tx_sent: cover property (TX_ACTIVE && TX_DONE);
  c_rx_irq: cover property ($rose(IRQ_RX));
  c_err_irq: cover property ($rose(IRQ_ERROR));
  c_wake_irq: cover property ($rose(IRQ_WAKEUP));
endmodule

// >>> test/can_engine_model.sv
// engine-side model: arbitration, frames, error counters and sleep
`timescale 1ns/1ps
module can_engine_model (
  input  wire logic                 clock,
  output can_filter_pkg::rx_frame_s rx_frame,
  output logic                      rx_frame_ok,
  output logic                      rx_late_stuff,
  output logic                      arb_start,
  output logic                      tx_done,
  output logic                      tx_fail,
  output logic [7:0]                rx_err_count,
  output logic [8:0]                tx_err_count,
  output logic                      sleep_ack,
  output logic                      bus_activity
);
  initial
  begin
    rx_late_stuff = 1'b0;
    rx_frame = '0;
    rx_frame_ok = 1'b0;
    arb_start = 1'b0;
    tx_done = 1'b0;
    tx_fail = 1'b0;
    rx_err_count = 8'h00;
    tx_err_count = 9'h000;
    sleep_ack = 1'b0;
    bus_activity = 1'b0;
  end
  task automatic start_arb();
    @(posedge clock);
    arb_start <= 1'b1;
    @(posedge clock);
    arb_start <= 1'b0;
  endtask
  // slow lets the frame run on for a while before it ends
  task automatic finish(input logic ok, input int slow);
    repeat (slow) @(posedge clock);
    @(posedge clock);
    tx_done <= ok;
    tx_fail <= !ok;
    @(posedge clock);
    tx_done <= 1'b0;
    tx_fail <= 1'b0;
  endtask
  // late marks a stuff bit between id16 and id15
  task automatic frame_in(input can_filter_pkg::rx_frame_s f,
                          input logic late);
    @(posedge clock);
    rx_frame_ok <= 1'b1;
    rx_frame <= f;
    rx_late_stuff <= late;
    @(posedge clock);
    rx_frame_ok <= 1'b0;
    rx_late_stuff <= 1'b0;
    // stale id must not look valid after the strobe
    rx_frame <= ~rx_frame;
  endtask
  // standard frame; id bits 10..3 carry top
  task automatic send(input logic [7:0] top);
    frame_in({18'h0, top, 3'h0, 3'h0}, 1'b0);
  endtask
  task automatic counts(input logic [7:0] rx, input logic [8:0] tx);
    @(posedge clock);
    rx_err_count <= rx;
    tx_err_count <= tx;
  endtask
  task automatic sleep(input logic s);
    @(posedge clock);
    sleep_ack <= s;
  endtask
  task automatic activity();
    @(posedge clock);
    bus_activity <= 1'b1;
    @(posedge clock);
    bus_activity <= 1'b0;
  endtask
endmodule

// >>> test/testbench.sv
// self-checking bench for the can filter/abort block
`timescale 1ns/1ps
module testbench;
  logic                      clock;
  logic                      rst_n;
  can_filter_pkg::reg_req_s  req;
  logic [7:0]                rdata;
  can_filter_pkg::rx_frame_s frame;
  logic                      frame_ok;
  logic                      late;
  logic                      arb;
  logic                      done;
  logic                      fail;
  logic                      active;
  logic [1:0]                tbuf;
  logic [7:0]                rx_err;
  logic [8:0]                tx_err;
  logic                      slp;
  logic                      act;
  logic                      irq_w;
  logic                      irq_e;
  logic                      irq_r;
  logic                      irq_t;
  int                        n_fail;
  int                        n_compared;
  logic [7:0] codes [4] = '{8'h11, 8'h22, 8'h33, 8'h44};
  logic [7:0] masks [4] = '{8'h00, 8'h00, 8'h00, 8'hff};
  logic [7:0] rxc [5] = '{8'h5f, 8'h60, 8'h7f, 8'h80, 8'hff};
  logic [8:0] txc [5] = '{9'h05f, 9'h060, 9'h07f, 9'h0ff, 9'h100};
  logic [7:0] flg [5] = '{8'h00, 8'h60, 8'h60, 8'h78, 8'h7c};
  // id17 and id16 set so the shifted byte differs only where masked
  logic [28:0] ext_id = {8'ha5, 3'h3, 3'h6, 8'h3c, 7'h00};
  logic [7:0] ext_code [4] = '{8'ha5, 8'h7e, 8'h3c, 8'h00};
  can_filter_abort_irq can_filter_abort_irq_inst (
    .CLOCK(clock), .RST_N(rst_n), .REG_REQ(req), .REG_RDATA(rdata),
    .ARB_START(arb), .TX_DONE(done), .TX_FAIL(fail),
    .TX_ACTIVE(active), .TX_BUFFER(tbuf), .RX_FRAME_OK(frame_ok),
    .RX_FRAME(frame), .RX_LATE_STUFF(late), .RX_ERR_COUNT(rx_err),
    .TX_ERR_COUNT(tx_err), .SLEEP_ACK(slp), .BUS_ACTIVITY(act),
    .IRQ_WAKEUP(irq_w), .IRQ_ERROR(irq_e), .IRQ_RX(irq_r),
    .IRQ_TX(irq_t)
  );
  can_engine_model can_engine_model_inst (
    .clock(clock), .rx_frame(frame), .rx_frame_ok(frame_ok),
    .rx_late_stuff(late), .arb_start(arb), .tx_done(done),
    .tx_fail(fail), .rx_err_count(rx_err), .tx_err_count(tx_err),
    .sleep_ack(slp), .bus_activity(act)
  );
  initial clock = 1'b0;
  always #4 clock = ~clock;
  task automatic conclude();
    if (n_fail == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] got,
                     input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clock);
    req <= '{data: d, addr: a, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    req.wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    @(posedge clock);
    req <= '{data: 8'h00, addr: a, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    req.rd <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), rdata, e);
  endtask
  task automatic arb_to(input logic [1:0] b);
    can_engine_model_inst.start_arb();
    #1;
    chk("tx_active", {7'h0, active}, 8'h01);
    chk("tx_buffer", {6'h0, tbuf}, {6'h0, b});
  endtask
  initial
  begin
    n_fail = 0;
    n_compared = 0;
    rst_n = 1'b0;
    req = '0;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    rd(can_filter_pkg::OFS_CTRL0, 8'h01);
    rd(can_filter_pkg::OFS_TXFLAG, 8'h07);
    wr(can_filter_pkg::OFS_ACCCTRL, 8'h20);
    for (int i = 0; i < 4; i++)
    begin
      wr(can_filter_pkg::OFS_CODE0 + 6'(i), codes[i]);
      wr(can_filter_pkg::OFS_MASK0 + 6'(i), masks[i]);
    end
    rd(can_filter_pkg::OFS_MASK0 + 6'h3, 8'hff);
    wr(can_filter_pkg::OFS_CTRL0, 8'h00);
    wr(can_filter_pkg::OFS_CODE0, 8'h55);
    rd(can_filter_pkg::OFS_CODE0, 8'h11);
    wr(can_filter_pkg::OFS_MASK0, 8'h0f);
    rd(can_filter_pkg::OFS_MASK0, 8'h00);
    wr(can_filter_pkg::OFS_ACCCTRL, 8'h30);
    rd(can_filter_pkg::OFS_ACCCTRL, 8'h20);
    wr(can_filter_pkg::OFS_RXIEN, 8'hff);
    wr(can_filter_pkg::OFS_TXCTRL, 8'h07);
    #1 chk("irq_tx", {7'h0, irq_t}, 8'h01);
    wr(can_filter_pkg::OFS_PRIO0, 8'h30);
    wr(can_filter_pkg::OFS_PRIO0 + 6'h1, 8'h10);
    wr(can_filter_pkg::OFS_PRIO0 + 6'h2, 8'h20);
    wr(can_filter_pkg::OFS_TXFLAG, 8'h07);
    #1 chk("irq_tx", {7'h0, irq_t}, 8'h00);
    arb_to(2'h1);
    can_engine_model_inst.finish(1'b0, 2);
    wr(can_filter_pkg::OFS_PRIO0 + 6'h1, 8'h40);
    arb_to(2'h2);
    can_engine_model_inst.finish(1'b1, 0);
    rd(can_filter_pkg::OFS_TXFLAG, 8'h04);
    chk("irq_tx", {7'h0, irq_t}, 8'h01);
    arb_to(2'h0);
    wr(can_filter_pkg::OFS_TXCTRL, 8'h37);
    rd(can_filter_pkg::OFS_TXFLAG, 8'h26);
    chk("tx_active", {7'h0, active}, 8'h01);
    can_engine_model_inst.finish(1'b1, 1);
    rd(can_filter_pkg::OFS_TXFLAG, 8'h27);
    can_engine_model_inst.send(8'h33);
    #1 chk("irq_rx", {7'h0, irq_r}, 8'h01);
    rd(can_filter_pkg::OFS_ACCCTRL, 8'h22);
    can_engine_model_inst.send(8'h22);
    can_engine_model_inst.send(8'h34);
    rd(can_filter_pkg::OFS_RXFLAG, 8'h03);
    chk("irq_error", {7'h0, irq_e}, 8'h01);
    wr(can_filter_pkg::OFS_RXFLAG, 8'h01);
    rd(can_filter_pkg::OFS_RXFLAG, 8'h03);
    rd(can_filter_pkg::OFS_ACCCTRL, 8'h21);
    wr(can_filter_pkg::OFS_RXFLAG, 8'h03);
    rd(can_filter_pkg::OFS_RXFLAG, 8'h00);
    can_engine_model_inst.send(8'h34);
    rd(can_filter_pkg::OFS_ACCCTRL, 8'h23);
    wr(can_filter_pkg::OFS_RXFLAG, 8'h01);
    wr(can_filter_pkg::OFS_CTRL0, 8'h01);
    wr(can_filter_pkg::OFS_ACCCTRL, 8'h30);
    wr(can_filter_pkg::OFS_CTRL0, 8'h00);
    can_engine_model_inst.send(8'h33);
    rd(can_filter_pkg::OFS_RXFLAG, 8'h00);
    for (int i = 0; i < 5; i++)
    begin
      can_engine_model_inst.counts(rxc[i], txc[i]);
      wr(can_filter_pkg::OFS_RXFLAG, 8'h60);
      rd(can_filter_pkg::OFS_RXFLAG, flg[i]);
    end
    wr(can_filter_pkg::OFS_RXFLAG, 8'hff);
    rd(can_filter_pkg::OFS_RXFLAG, 8'h7c);
    wr(can_filter_pkg::OFS_RXERR, 8'h00);
    rd(can_filter_pkg::OFS_RXERR, 8'hff);
    rd(can_filter_pkg::OFS_TXERR, 8'h00);
    can_engine_model_inst.counts(8'h00, 9'h000);
    wr(can_filter_pkg::OFS_RXFLAG, 8'hff);
    rd(can_filter_pkg::OFS_RXFLAG, 8'h00);
    chk("irq_error", {7'h0, irq_e}, 8'h00);
    can_engine_model_inst.activity();
    #1 chk("irq_wakeup", {7'h0, irq_w}, 8'h00);
    can_engine_model_inst.sleep(1'b1);
    rd(can_filter_pkg::OFS_CTRL0, 8'h02);
    can_engine_model_inst.activity();
    #1 chk("irq_wakeup", {7'h0, irq_w}, 8'h01);
    can_engine_model_inst.sleep(1'b0);
    wr(can_filter_pkg::OFS_RXFLAG, 8'h80);
    #1 chk("irq_wakeup", {7'h0, irq_w}, 8'h00);
    wr(can_filter_pkg::OFS_CTRL0, 8'h01);
    wr(can_filter_pkg::OFS_ACCCTRL, 8'h00);
    wr(can_filter_pkg::OFS_MASK0 + 6'h3, 8'h00);
    for (int i = 0; i < 4; i++)
      wr(can_filter_pkg::OFS_CODE0 + 6'(i), ext_code[i]);
    wr(can_filter_pkg::OFS_CTRL0, 8'h00);
    can_engine_model_inst.frame_in({ext_id, 3'h5}, 1'b1);
    rd(can_filter_pkg::OFS_RXFLAG, 8'h00);
    can_engine_model_inst.frame_in({ext_id, 3'h5}, 1'b0);
    rd(can_filter_pkg::OFS_RXFLAG, 8'h01);
    rd(can_filter_pkg::OFS_RXID0 + 6'h1, 8'h7e);
    wr(can_filter_pkg::OFS_RXFLAG, 8'h01);
    wr(can_filter_pkg::OFS_CTRL0, 8'h01);
    wr(can_filter_pkg::OFS_ACCCTRL, 8'h10);
    wr(can_filter_pkg::OFS_MASK0 + 6'h1, 8'hf1);
    wr(can_filter_pkg::OFS_CTRL0, 8'h00);
    can_engine_model_inst.frame_in({ext_id, 3'h5}, 1'b1);
    rd(can_filter_pkg::OFS_RXFLAG, 8'h01);
    wr(can_filter_pkg::OFS_RXFLAG, 8'h01);
    can_engine_model_inst.send(8'h3c);
    rd(can_filter_pkg::OFS_ACCCTRL, 8'h11);
    conclude();
  end
  // the whole sequence needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge clock);
    $display("CHECK FAILED watchdog expected finish seen timeout");
    n_fail++;
    conclude();
  end
endmodule
bind can_filter_abort_irq can_filter_abort_irq_chk chk_inst (
  .CLOCK, .RST_N, .REG_REQ, .ARB_START, .TX_DONE, .TX_FAIL, .TX_ACTIVE,
  .TX_BUFFER, .RX_FRAME_OK, .RX_ERR_COUNT, .TX_ERR_COUNT, .SLEEP_ACK,
  .BUS_ACTIVITY, .IRQ_WAKEUP, .IRQ_ERROR, .IRQ_RX, .IRQ_TX
);
